// File: logic/pld_defs.vh
// Constants for the PLL lock-detect block
`ifndef PLD_DEFS_VH
`define PLD_DEFS_VH
// Lock-count select: 0..3 -> required consecutive in-window cycles
`define PLD_CNT_SEL0    16'h0005
`define PLD_CNT_SEL1    16'h0010
`define PLD_CNT_SEL2    16'h0040
`define PLD_CNT_SEL3    16'h00FF
// Base windows in system clock cycles (8 ns each)
`define PLD_LOCK_WIN    8'h01
`define PLD_UNLOCK_WIN  8'h03
// Extra window cycles added per antibacklash step
`define PLD_ABL_STEP    8'h01
// Total delay-cell span 1 ns at 125 MHz rounds down to zero; one-cycle floor
`define PLD_DELAY_SPAN_PS   1000
`define PLD_CLK_PERIOD_PS   8000
// Pin mux selections
`define PLD_MUX_LOW     2'h0
`define PLD_MUX_DLI     2'h1
`define PLD_MUX_ALD     2'h2
`define PLD_MUX_HIGH    2'h3
// Analog lock output modes
`define PLD_ALD_OFF     2'h0
`define PLD_ALD_NCH     2'h1
`define PLD_ALD_PCH     2'h2
// Prescaler modes
`define PLD_PRE_FD      1'b0
`define PLD_PRE_DM      1'b1
`endif

// File: logic/pld_delay_cell.v
// Programmable three-bit edge delay cell for a divider output
`timescale 1ns/1ps
module pld_delay_cell (
    input  wire       clk,     // System clock
    input  wire       rst,     // Synchronous reset
    input  wire       en,      // Delay enable
    input  wire [2:0] sel,     // Delay step
    input  wire       din,     // Divider output
    output wire       dout     // Delayed output
);
    // A sub-ns span cannot be resolved at 8 ns; each step is one clock
    // Step 0 is the undelayed input, so a step count equals its delay in clocks
    reg  [6:0] tap;
    wire [7:0] line = {tap, din};
    always @(posedge clk)
    begin
        if (rst)
            tap <= 7'h00;
        else
            tap <= {tap[5:0], din};
    end
    assign dout = en ? line[sel] : din;
endmodule

// File: logic/pld_fb_divider.v
// Feedback divider: prescaler, main and swallow counters
`timescale 1ns/1ps
`include "pld_defs.vh"
module pld_fb_divider (
    input  wire        clk,       // System clock
    input  wire        rst,       // Synchronous reset
    input  wire        en,        // One synchronised feedback edge
    input  wire        mode,      // Fixed-divide or dual-modulus
    input  wire [5:0]  pre_p,     // Prescaler ratio P
    input  wire [12:0] main_b,    // Main counter B
    input  wire [5:0]  swal_a,    // Swallow counter A
    output reg         fb_pulse   // One pulse per N input cycles
);
    reg  [18:0] cnt;
    wire [18:0] n_total;
    wire [18:0] pb = pre_p * main_b;
    // A used only in dual-modulus mode
    assign n_total = (mode == `PLD_PRE_FD) ?
                     ((main_b <= 13'h0001) ? {13'h0000, pre_p} : pb) :
                     (pb + {13'h0000, swal_a});
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt      <= 19'h00000;
            fb_pulse <= 1'b0;
        end
        else if (en)
        begin
            if (cnt + 19'h00001 >= n_total)
            begin
                cnt      <= 19'h00000;
                fb_pulse <= 1'b1;
            end
            else
            begin
                cnt      <= cnt + 19'h00001;
                fb_pulse <= 1'b0;
            end
        end
        else
            fb_pulse <= 1'b0;
    end
endmodule

// File: logic/pld_lock_detect.v
// PLL lock detect: digital lock indicator, analog lock pulses, pin muxes
// How it works
// - Reference and feedback paths each have a three-bit delay cell, one clock (8 ns) per step, up to seven clocks.
// - Lock asserts after programmed count of consecutive in-window comparisons.
// - Once locked, one comparison beyond unlock window clears lock immediately.
// - Unlock window is wider than lock window for hysteresis.
// - Window timing depends on window select bit and antibacklash setting.
// - Lock indicator routes through per-pin muxes to three output pins.
// - N-channel mode: output idles high with brief low pulses.
// - P-channel mode: output idles low with brief high pulses.
// - Fixed-divide mode ignores swallow counter: N equals P times B.
// - Fixed-divide with B of zero or one bypasses counters: N equals P.
`timescale 1ns/1ps
`include "pld_defs.vh"
module pld_lock_detect (
    input  wire        SYS_CLK,        // 125 MHz clock
    input  wire        RST,            // Synchronous reset, active high
    input  wire        REF_IN,         // Reference divider output pin
    input  wire        FB_CLK_IN,      // Feedback (VCO) clock pin, counted
    input  wire        REF_DLY_EN,     // Reference delay enable
    input  wire [2:0]  REF_DLY_SEL,    // Reference delay step
    input  wire        FB_DLY_EN,      // Feedback delay enable
    input  wire [2:0]  FB_DLY_SEL,     // Feedback delay step
    input  wire        PRE_MODE,       // 0 fixed-divide, 1 dual-modulus
    input  wire [5:0]  PRE_RATIO,      // Prescaler ratio P
    input  wire [12:0] MAIN_CNT,       // Main counter B
    input  wire [5:0]  SWALLOW_CNT,    // Swallow counter A
    input  wire [1:0]  LOCK_CNT_SEL,   // Consecutive-cycle count select
    input  wire        LOCK_WIN_SEL,   // Wide window select
    input  wire [1:0]  ANTIBACKLASH,   // Antibacklash pulse width
    input  wire [1:0]  ALD_MODE,       // Analog lock output mode
    input  wire [1:0]  LD_MUX,         // Lock detect pin source
    input  wire [1:0]  STATUS_MUX,     // Status pin source
    input  wire [1:0]  REFERENCE_MONITOR_PIN_MUX,     // Reference monitor pin source
    output reg         LOCK_DETECT_PIN,// Lock detect pin level
    output reg         LOCK_DETECT_OE, // Lock detect pin drive enable
    output reg         STATUS_PIN,     // Status pin
    output reg         REFERENCE_MONITOR_PIN, // Reference monitor pin
    output reg         DIGITAL_LOCK_INDICATOR // Lock indicator state
);
    // Three-stage pin synchronisers
    reg [2:0] ref_sync;
    reg [2:0] fbk_sync;
    reg       ref_state;
    reg       fbk_state;
    // Reference waits two clocks to match the divider and toggle registers
    reg [1:0] ref_pipe;
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ref_sync  <= 3'h0;
            fbk_sync  <= 3'h0;
            ref_state <= 1'b0;
            fbk_state <= 1'b0;
            ref_pipe  <= 2'h0;
        end
        else
        begin
            ref_sync <= {ref_sync[1:0], REF_IN};
            fbk_sync <= {fbk_sync[1:0], FB_CLK_IN};
            ref_pipe <= {ref_pipe[0], ref_state};
            if (ref_sync[1] == ref_sync[2])
                ref_state <= ref_sync[2];
            if (fbk_sync[1] == fbk_sync[2])
                fbk_state <= fbk_sync[2];
        end
    end

    reg  fbk_prev;
    always @(posedge SYS_CLK)
    begin
        if (RST)
            fbk_prev <= 1'b0;
        else
            fbk_prev <= fbk_state;
    end

    // The divider steps once per synchronised feedback edge, never on a derived clock
    wire fb_edge = fbk_state & ~fbk_prev;
    reg  fb_toggle;
    wire fb_raw;
    pld_fb_divider u_fbdiv (
        .clk      (SYS_CLK),
        .rst      (RST),
        .en       (fb_edge),
        .mode     (PRE_MODE),
        .pre_p    (PRE_RATIO),
        .main_b   (MAIN_CNT),
        .swal_a   (SWALLOW_CNT),
        .fb_pulse (fb_raw)
    );
    // Each divided edge flips the comparator input; both flips count as rises
    always @(posedge SYS_CLK)
    begin
        if (RST)
            fb_toggle <= 1'b0;
        else if (fb_raw)
            fb_toggle <= ~fb_toggle;
    end

    wire ref_dly;
    wire fb_dly;
    pld_delay_cell u_rdly (
        .clk  (SYS_CLK),
        .rst  (RST),
        .en   (REF_DLY_EN),
        .sel  (REF_DLY_SEL),
        .din  (ref_pipe[1]),
        .dout (ref_dly)
    );
    pld_delay_cell u_fdly (
        .clk  (SYS_CLK),
        .rst  (RST),
        .en   (FB_DLY_EN),
        .sel  (FB_DLY_SEL),
        .din  (fb_toggle),
        .dout (fb_dly)
    );

    // Rising edges at the comparator inputs
    reg  ref_d;
    reg  fb_d;
    wire ref_rise = ref_dly & ~ref_d;
    wire fb_rise  = fb_dly ^ fb_d;
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ref_d <= 1'b0;
            fb_d  <= 1'b0;
        end
        else
        begin
            ref_d <= ref_dly;
            fb_d  <= fb_dly;
        end
    end

    // Window widths: unlock always wider than lock
    function [7:0] win_width;
        input       base_sel;
        input       wide;
        input [1:0] abl;
        begin
            win_width = (base_sel ? `PLD_UNLOCK_WIN : `PLD_LOCK_WIN)
                      + (wide ? `PLD_LOCK_WIN : 8'h00)
                      + ({6'h00, abl} * `PLD_ABL_STEP);
        end
    endfunction
    wire [7:0] lock_win   = win_width(1'b0, LOCK_WIN_SEL, ANTIBACKLASH);
    wire [7:0] unlock_win = win_width(1'b1, LOCK_WIN_SEL, ANTIBACKLASH)
                          + lock_win;

    function [15:0] cnt_need;
        input [1:0] s;
        begin
            if (s == 2'h0)
                cnt_need = `PLD_CNT_SEL0;
            else if (s == 2'h1)
                cnt_need = `PLD_CNT_SEL1;
            else if (s == 2'h2)
                cnt_need = `PLD_CNT_SEL2;
            else
                cnt_need = `PLD_CNT_SEL3;
        end
    endfunction

    // Comparison: first edge opens a measurement, the second closes it
    localparam ST_IDLE = 3'b001;
    localparam ST_REF  = 3'b010;
    localparam ST_FB   = 3'b100;
    reg  [2:0]  state;
    reg  [7:0]  diff;
    reg         cmp_done;
    reg  [7:0]  cmp_diff;
    reg  [15:0] run;
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            state    <= ST_IDLE;
            diff     <= 8'h00;
            cmp_done <= 1'b0;
            cmp_diff <= 8'h00;
        end
        else
        begin
            cmp_done <= 1'b0;
            case (state)
            ST_IDLE:
            begin
                diff <= 8'h00;
                if (ref_rise & fb_rise)
                begin
                    cmp_done <= 1'b1;
                    cmp_diff <= 8'h00;
                end
                else if (ref_rise)
                    state <= ST_REF;
                else if (fb_rise)
                    state <= ST_FB;
            end
            ST_REF, ST_FB:
            begin
                if ((state == ST_REF && fb_rise) || (state == ST_FB && ref_rise))
                begin
                    cmp_done <= 1'b1;
                    cmp_diff <= diff + 8'h01;
                    state    <= ST_IDLE;
                end
                else if (diff != 8'hFF)
                    diff <= diff + 8'h01;
            end
            default:
                state <= ST_IDLE;
            endcase
        end
    end
    // Edge pair separated beyond the unlock window counts as unlock at once
    wire overdue = (state != ST_IDLE) && (diff >= unlock_win);

    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            run                    <= 16'h0000;
            DIGITAL_LOCK_INDICATOR <= 1'b0;
        end
        else if (DIGITAL_LOCK_INDICATOR)
        begin
            if ((cmp_done && cmp_diff > unlock_win) || overdue)
            begin
                DIGITAL_LOCK_INDICATOR <= 1'b0;
                run                    <= 16'h0000;
            end
        end
        else if (cmp_done)
        begin
            if (cmp_diff < lock_win)
            begin
                if (run + 16'h0001 >= cnt_need(LOCK_CNT_SEL))
                    DIGITAL_LOCK_INDICATOR <= 1'b1;
                run <= run + 16'h0001;
            end
            else
                run <= 16'h0000;
        end
    end

    // Analog lock: pulse active while the two edges disagree
    wire phase_err = (state != ST_IDLE);
    reg  ald_level;
    reg  ald_oe;
    always @*
    begin
        ald_level = 1'b0;
        ald_oe    = 1'b0;
        case (ALD_MODE)
        `PLD_ALD_NCH:
        begin
            ald_level = 1'b0;
            ald_oe    = phase_err;
        end
        `PLD_ALD_PCH:
        begin
            ald_level = 1'b1;
            ald_oe    = phase_err;
        end
        default:
        begin
            ald_level = 1'b0;
            ald_oe    = 1'b0;
        end
        endcase
    end

    function pin_src;
        input [1:0] s;
        input       dli;
        input       analog_lock_output;
        begin
            if (s == `PLD_MUX_DLI)
                pin_src = dli;
            else if (s == `PLD_MUX_ALD)
                pin_src = analog_lock_output;
            else if (s == `PLD_MUX_HIGH)
                pin_src = 1'b1;
            else
                pin_src = 1'b0;
        end
    endfunction

    wire ald_view = (ALD_MODE == `PLD_ALD_NCH) ? ~phase_err : phase_err;
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            LOCK_DETECT_PIN       <= 1'b0;
            LOCK_DETECT_OE        <= 1'b0;
            STATUS_PIN            <= 1'b0;
            REFERENCE_MONITOR_PIN <= 1'b0;
        end
        else
        begin
            if (LD_MUX == `PLD_MUX_ALD && ALD_MODE != `PLD_ALD_OFF)
            begin
                LOCK_DETECT_PIN <= ald_level;
                LOCK_DETECT_OE  <= ald_oe;
            end
            else
            begin
                LOCK_DETECT_PIN <= pin_src(LD_MUX, DIGITAL_LOCK_INDICATOR, ald_view);
                LOCK_DETECT_OE  <= 1'b1;
            end
            STATUS_PIN            <= pin_src(STATUS_MUX, DIGITAL_LOCK_INDICATOR, ald_view);
            REFERENCE_MONITOR_PIN <= pin_src(REFERENCE_MONITOR_PIN_MUX, DIGITAL_LOCK_INDICATOR, ald_view);
        end
    end
endmodule

// File: sim/pld_lock_detect_properties.sv
// Port-level checks for the lock-detect block
`timescale 1ns/1ps
module pld_lock_detect_properties (
    input wire       SYS_CLK, // Clock
    input wire       RST, // Reset
    input wire       REF_IN, // Reference edges
    input wire       FB_CLK_IN, // Feedback edges
    input wire [1:0] LOCK_CNT_SEL, // Run select
    input wire [1:0] ALD_MODE, // Analog mode
    input wire [1:0] LD_MUX, // LD source
    input wire [1:0] STATUS_MUX, // Status source
    input wire       LOCK_DETECT_PIN, // LD level
    input wire       LOCK_DETECT_OE, // LD drive
    input wire       STATUS_PIN, // Status level
    input wire       DIGITAL_LOCK_INDICATOR // Lock state
);
    reg         ref_q;
    reg         fb_q;
    reg  [15:0] refs;
    reg  [7:0]  quiet;
    wire        nch = ALD_MODE == 2'h1 && LD_MUX == 2'h2;
    wire        pch = ALD_MODE == 2'h2 && LD_MUX == 2'h2;
    wire [15:0] need = LOCK_CNT_SEL == 2'h0 ? 16'h0005 : LOCK_CNT_SEL == 2'h1 ? 16'h0010 :
                       LOCK_CNT_SEL == 2'h2 ? 16'h0040 : 16'h00FF;

    // Raw reference rises lead the design's own count, so the lock bound cannot misfire
    always @(posedge SYS_CLK)
    begin
        ref_q <= REF_IN;
        fb_q  <= FB_CLK_IN;
        refs  <= RST ? 16'h0000 : refs + {15'h0000, REF_IN && !ref_q};
        quiet <= (RST || REF_IN != ref_q || FB_CLK_IN != fb_q) ? 8'h00 :
                 quiet + {7'h00, quiet != 8'hFF};
    end

    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_lock_after_run: assert property ($rose(DIGITAL_LOCK_INDICATOR) |-> refs >= need)
        else $error("lock before required run");
    a_unlock_on_edge: assert property ($fell(DIGITAL_LOCK_INDICATOR) |-> quiet < 8'h28)
        else $error("lock dropped with no edges");
    a_status_forced_low: assert property ((STATUS_MUX == 2'h0)[*3] |-> !STATUS_PIN)
        else $error("status not low");
    a_status_forced_high: assert property ((STATUS_MUX == 2'h3)[*3] |-> STATUS_PIN)
        else $error("status not high");
    a_status_follows_lock: assert property ((STATUS_MUX == 2'h1)[*3] |->
        STATUS_PIN == $past(DIGITAL_LOCK_INDICATOR)) else $error("status not tracking lock");
    a_nch_pulls_low: assert property ((nch[*3] ##0 LOCK_DETECT_OE) |-> !LOCK_DETECT_PIN)
        else $error("n-channel drove high");
    a_pch_pulls_high: assert property ((pch[*3] ##0 LOCK_DETECT_OE) |-> LOCK_DETECT_PIN)
        else $error("p-channel drove low");
    a_ald_idle_release: assert property ((nch || pch) && quiet >= 8'h28 |-> !LOCK_DETECT_OE)
        else $error("analog output driven while idle");

    c_lock: cover property ($rose(DIGITAL_LOCK_INDICATOR));
    c_unlock: cover property ($fell(DIGITAL_LOCK_INDICATOR));
    c_ald_pulse: cover property (nch && LOCK_DETECT_OE);
endmodule

bind pld_lock_detect pld_lock_detect_properties pld_lock_detect_properties_inst (
    .SYS_CLK, .RST, .REF_IN, .FB_CLK_IN, .LOCK_CNT_SEL, .ALD_MODE, .LD_MUX, .STATUS_MUX,
    .LOCK_DETECT_PIN, .LOCK_DETECT_OE, .STATUS_PIN, .DIGITAL_LOCK_INDICATOR);

// File: sim/pld_far_side.sv
// Far side: reference and feedback edge source, pulled lock line
`timescale 1ns/1ps
module pld_far_side #(
    parameter PERIOD = 48 // Comparison period in clocks
) (
    input wire       clk, // System clock
    input wire       run, // Edges only while high
    input wire [3:0] lag, // Feedback lag after reference
    input wire       fast, // Two feedback pulses per period
    input wire       pull_up, // 1 pull-up, 0 pull-down
    input wire       pin, // Lock pin level
    input wire       oe, // Lock pin drive enable
    output reg       ref_out, // Reference divider output
    output reg       fb_out, // Feedback clock
    output wire      lock_line // Resolved lock line
);
    reg [7:0] ph;
    reg       first;

    // Period far above the widest unlock window, so every pair is judged cleanly
    // In fast mode the first period skips its aligned pulse, so every second
    // feedback pulse lines up with the reference
    always @(posedge clk)
    begin
        ph      <= (!run || ph == PERIOD - 1) ? 8'h00 : ph + 8'h01;
        first   <= !run || (first && ph != PERIOD - 1);
        ref_out <= run && ph < 8'h04;
        fb_out  <= run && ((!(fast && first) && ph >= {4'h0, lag} && ph < {4'h0, lag} + 8'h04)
                   || (fast && ph >= {4'h0, lag} + 8'h18 && ph < {4'h0, lag} + 8'h1C));
    end

    // Released line falls back to the external resistor
    assign lock_line = oe ? pin : pull_up;
endmodule

// File: sim/pld_lock_detect_bench.sv
// Self-checking bench for the lock-detect block
`timescale 1ns/1ps
module pld_lock_detect_bench;
    reg        sys_clk = 1'b0;
    reg        rst = 1'b1;
    reg        run = 1'b0;
    reg        ref_dly_en = 1'b0;
    reg        fb_dly_en = 1'b0;
    reg        lock_win_sel = 1'b0;
    reg  [3:0] lag = 4'h0;
    reg        pre_mode = 1'b0;
    reg        fast = 1'b0;
    reg  [5:0] pre_ratio = 6'h01;
    reg  [5:0] swallow_cnt = 6'h07;
    reg [12:0] main_cnt = 13'h0001;
    reg  [2:0] ref_dly_sel = 3'h0;
    reg  [2:0] fb_dly_sel = 3'h0;
    reg  [1:0] lock_cnt_sel = 2'h0;
    reg  [1:0] antibacklash = 2'h0;
    reg  [1:0] ald_mode = 2'h0;
    reg  [1:0] ld_mux = 2'h1;
    reg  [1:0] status_mux = 2'h1;
    reg  [1:0] reference_monitor_pin_mux = 2'h1;
    wire       ref_in, fb_in, ld_pin, ld_oe, status_pin, reference_monitor_pin_pin, dli, ld_line;
    integer    fails = 0;
    integer    checked = 0;
    integer    cycles = 0;

    always #4 sys_clk = ~sys_clk;

    // Default divide is fixed mode with B of one: N is P alone, swallow value ignored
    pld_lock_detect pld_lock_detect_inst (.SYS_CLK(sys_clk), .RST(rst), .REF_IN(ref_in),
        .FB_CLK_IN(fb_in), .REF_DLY_EN(ref_dly_en), .REF_DLY_SEL(ref_dly_sel),
        .FB_DLY_EN(fb_dly_en), .FB_DLY_SEL(fb_dly_sel), .PRE_MODE(pre_mode),
        .PRE_RATIO(pre_ratio), .MAIN_CNT(main_cnt), .SWALLOW_CNT(swallow_cnt),
        .LOCK_CNT_SEL(lock_cnt_sel), .LOCK_WIN_SEL(lock_win_sel), .ANTIBACKLASH(antibacklash),
        .ALD_MODE(ald_mode), .LD_MUX(ld_mux), .STATUS_MUX(status_mux), .REFERENCE_MONITOR_PIN_MUX(reference_monitor_pin_mux),
        .LOCK_DETECT_PIN(ld_pin), .LOCK_DETECT_OE(ld_oe), .STATUS_PIN(status_pin),
        .REFERENCE_MONITOR_PIN(reference_monitor_pin_pin), .DIGITAL_LOCK_INDICATOR(dli));

    pld_far_side pld_far_side_inst (.clk(sys_clk), .run(run), .lag(lag), .fast(fast),
        .pull_up(ald_mode == 2'h1), .pin(ld_pin), .oe(ld_oe), .ref_out(ref_in),
        .fb_out(fb_in), .lock_line(ld_line));

    task cyc(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask

    task chk(input [63:0] what, input exp, input got);
        begin
            checked = checked + 1;
            fails = fails + (got !== exp);
            if (got !== exp)
                $display("BAD %0s expected %b seen %b", what, exp, got);
        end
    endtask

    task end_sim;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task start(input [3:0] l, input [1:0] sel);
        begin
            rst = 1'b1;
            run = 1'b0;
            cyc(4);
            lag = l;
            lock_cnt_sel = sel;
            rst = 1'b0;
            run = 1'b1;
        end
    endtask

    task t_count;
        integer i;
        integer need;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                need = (i == 0) ? 5 : (i == 1) ? 16 : (i == 2) ? 64 : 255;
                start(4'h0, i[1:0]);
                cyc(48 * (need - 1));
                chk("early", 1'b0, dli);
                cyc(48);
                chk("lock", 1'b1, dli);
            end
        end
    endtask

    task t_hold;
        begin
            start(4'h0, 2'h0);
            cyc(48 * 4);
            lag = 4'h2;
            cyc(48);
            lag = 4'h0;
            cyc(48 * 4);
            chk("restart", 1'b0, dli);
            cyc(48);
            chk("relock", 1'b1, dli);
            lag = 4'h2;
            cyc(48 * 3);
            chk("hyst", 1'b1, dli);
            lag = 4'hC;
            cyc(48);
            chk("unlock", 1'b0, dli);
        end
    endtask

    // Wider windows and the reference delay cell turn a two-clock lag into a lock; feedback delay on aligned edges blocks one
    task t_window;
        begin
            antibacklash = 2'h3;
            lock_win_sel = 1'b1;
            start(4'h2, 2'h0);
            cyc(48 * 5);
            chk("wide", 1'b1, dli);
            lag = 4'h8;
            cyc(48 * 2);
            chk("widehold", 1'b1, dli);
            antibacklash = 2'h0;
            lock_win_sel = 1'b0;
            ref_dly_en = 1'b1;
            ref_dly_sel = 3'h2;
            start(4'h2, 2'h0);
            cyc(48 * 5);
            chk("refdly", 1'b1, dli);
            ref_dly_en = 1'b0;
            fb_dly_en = 1'b1;
            fb_dly_sel = 3'h2;
            start(4'h0, 2'h0);
            cyc(48 * 6);
            chk("fbdly", 1'b0, dli);
            fb_dly_en = 1'b0;
        end
    endtask

    task t_mux;
        integer m;
        begin
            start(4'h0, 2'h0);
            cyc(48 * 6);
            for (m = 0; m < 4; m = m + 1)
            begin
                ld_mux = m[1:0];
                status_mux = m[1:0];
                reference_monitor_pin_mux = m[1:0];
                cyc(4);
                // Analog view is low: aligned edges never open a pair
                chk("ldpin", m == 1 || m == 3, ld_pin);
                chk("ldoe", 1'b1, ld_oe);
                chk("status", m == 1 || m == 3, status_pin);
                chk("reference_monitor_pin", m == 1 || m == 3, reference_monitor_pin_pin);
            end
        end
    endtask

    // Feedback pulses twice per period, so only a total divide by two pairs up
    task div_try(input m, input [5:0] p, input [12:0] b, input [5:0] a);
        begin
            pre_mode = m;
            pre_ratio = p;
            main_cnt = b;
            swallow_cnt = a;
            start(4'h0, 2'h0);
            cyc(48 * 8);
        end
    endtask

    task t_div;
        begin
            fast = 1'b1;
            div_try(1'b0, 6'h02, 13'h0001, 6'h07);
            chk("fdbypass", 1'b1, dli);
            div_try(1'b0, 6'h01, 13'h0002, 6'h05);
            chk("fdnoswal", 1'b1, dli);
            div_try(1'b1, 6'h01, 13'h0001, 6'h01);
            chk("dualmod", 1'b1, dli);
            div_try(1'b0, 6'h01, 13'h0001, 6'h00);
            chk("undiv", 1'b0, dli);
            fast = 1'b0;
        end
    endtask

    task t_ald;
        integer k;
        reg seen;
        reg idle;
        begin
            ld_mux = 2'h2;
            for (k = 1; k < 3; k = k + 1)
            begin
                ald_mode = k[1:0];
                idle = (k == 1);
                seen = 1'b0;
                start(4'h6, 2'h0);
                repeat (96)
                begin
                    cyc(1);
                    if (ld_line !== idle)
                        seen = 1'b1;
                end
                chk("aldpulse", 1'b1, seen);
                run = 1'b0;
                cyc(50);
                chk("aldidle", idle, ld_line);
            end
            ald_mode = 2'h0;
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 25000)
        begin
            fails = fails + 1;
            end_sim;
        end
    end

    initial
    begin
        t_count;
        t_hold;
        t_window;
        t_mux;
        t_ald;
        t_div;
        end_sim;
    end
endmodule
